// *** logic/psg_consts.svh ***
// timing constants for the pseudo-static ram write guard
// assumes a 10 MHz ref_clk_i; every count derives from the period below
`ifndef PSG_CONSTS_SVH
`define PSG_CONSTS_SVH

`define PSG_CLK_PERIOD_NS 100
// longest select-active or address-valid time, in ns
`define PSG_MAX_SELECT_ACTIVE_TIME_NS 10000
`define PSG_WRITE_STROBE_WIDTH_NS 46
`define PSG_DATA_VALID_WINDOW_NS 23
`define PSG_WRITE_CYCLE_TIME_NS 70
`define PSG_READ_ACCESS_NS 70
// longest time rounds down, least times round up, none below one cycle
`define PSG_MAX_SEL_CYC (`PSG_MAX_SELECT_ACTIVE_TIME_NS / `PSG_CLK_PERIOD_NS)
`define PSG_WP_CYC ((`PSG_WRITE_STROBE_WIDTH_NS + `PSG_CLK_PERIOD_NS - 1) / `PSG_CLK_PERIOD_NS)
`define PSG_WC_CYC ((`PSG_WRITE_CYCLE_TIME_NS + `PSG_CLK_PERIOD_NS - 1) / `PSG_CLK_PERIOD_NS)
`define PSG_RD_CYC ((`PSG_READ_ACCESS_NS + `PSG_CLK_PERIOD_NS - 1) / `PSG_CLK_PERIOD_NS)
// select stays low load+1 cycles, so load two short of the limit
`define PSG_SEL_GUARD_LOAD (`PSG_MAX_SEL_CYC - 2)
// read waits access time plus the two-flop data synchroniser
`define PSG_RD_LOAD (`PSG_RD_CYC + 2)

`endif

// *** logic/psg_pkg.sv ***
// types shared by the write guard and its cycle timer
// assumes nothing beyond a systemverilog compiler
package psg_pkg;
  typedef logic [7:0] psg_len_t;
  typedef enum logic [2:0] {
    PSG_IDLE,
    PSG_SETUP,
    PSG_STROBE,
    PSG_READ,
    PSG_FINISH
  } psg_state_t;
endpackage

// *** logic/psg_timer.sv ***
// down-counting cycle timer; expired pulses load cycles after start
// assumes a synchronous active-high reset and load of at least one
`timescale 1ns/1ns
module psg_timer (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  psg_timer_if.timer tmr
);
  import psg_pkg::*;

  psg_len_t cnt_q;
  logic expired_q;

  // a new start always reloads, so a stale count never leaks into the next access
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_q <= 8'h00;
      expired_q <= 1'b0;
    end else if (tmr.start) begin
      cnt_q <= tmr.load;
      expired_q <= 1'b0;
    end else begin
      if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
      expired_q <= (cnt_q == 8'h01);
    end
  end

  assign tmr.expired = expired_q;
  assign tmr.busy = (cnt_q != 8'h00);
endmodule // psg_timer

// *** logic/psg_timer_if.sv ***
// carrier between the write guard and a cycle timer
// assumes owner and timer share ref_clk_i
`timescale 1ns/1ns
interface psg_timer_if;
  logic start;
  psg_pkg::psg_len_t load;
  logic expired;
  logic busy;
  modport owner (output start, output load, input expired, input busy);
  modport timer (input start, input load, output expired, output busy);
endinterface

// *** logic/psg_write_guard.sv ***
// host controller for an asynchronous pseudo-static ram, guarding its hidden refresh
// assumes a 10 MHz ref_clk_i, a synchronous reset and a ram on plain async pins
`timescale 1ns/1ns
`include "psg_consts.svh"
module psg_write_guard #(
  parameter int AW = 22,
  parameter int DW = 16
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_ext_i,
  input wire psg_pkg::psg_len_t req_len_i,
  input wire logic [AW-1:0] req_addr_i,
  input wire logic [DW-1:0] req_wdata_i,
  input wire logic page_mode_i,
  output logic req_ready_o,
  output logic done_o,
  output logic trunc_o,
  output logic [DW-1:0] rdata_o,
  output logic ce_n_o,
  output logic we_n_o,
  output logic oe_n_o,
  output logic [AW-1:0] addr_o,
  output logic [DW-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic [DW-1:0] dq_i
);
  import psg_pkg::*;

  // refuse settings the guard cannot honour
  if (`PSG_SEL_GUARD_LOAD < `PSG_WC_CYC || `PSG_SEL_GUARD_LOAD > 255) begin : g_bad_guard
    $error("select guard load out of range");
  end
  if (AW < 1 || DW < 1) begin : g_bad_width
    $error("address and data widths must be positive");
  end

  localparam psg_len_t GUARD_LOAD = 8'(`PSG_SEL_GUARD_LOAD);
  localparam psg_len_t RD_LOAD = 8'(`PSG_RD_LOAD);
  localparam psg_len_t WP_CYC = 8'(`PSG_WP_CYC);
  localparam psg_len_t WC_CYC = 8'(`PSG_WC_CYC);

  psg_state_t state_q;
  psg_len_t len_q;
  logic ext_q;
  logic [DW-1:0] dq_s1_q;
  logic [DW-1:0] dq_s2_q;
  logic accept;

  psg_timer_if sel_if ();
  psg_timer_if stb_if ();

  psg_timer u_sel_timer (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .tmr(sel_if.timer)
  );

  psg_timer u_stb_timer (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .tmr(stb_if.timer)
  );

  assign accept = req_valid_i && req_ready_o && (state_q == PSG_IDLE);

  // select guard starts with chip select on every write; strobe timer paces both kinds
  always_comb begin
    sel_if.start = accept && req_write_i;
    sel_if.load = GUARD_LOAD;
    stb_if.start = (accept && !req_write_i) || (state_q == PSG_SETUP);
    stb_if.load = (state_q == PSG_SETUP) ? len_q : RD_LOAD;
  end

  // data pins cross from the ram's domain through two flops
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  // access sequencer; the pins are flops so no glitch reaches the ram
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q <= PSG_IDLE;
      req_ready_o <= 1'b1;
      done_o <= 1'b0;
      trunc_o <= 1'b0;
      ce_n_o <= 1'b1;
      we_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      addr_o <= '0;
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      len_q <= 8'h00;
      ext_q <= 1'b0;
    end else begin
      done_o <= 1'b0;
      trunc_o <= 1'b0;
      case (state_q)
        PSG_IDLE: begin
          if (accept) begin
            req_ready_o <= 1'b0;
            ce_n_o <= 1'b0;
            addr_o <= req_addr_i;
            if (req_write_i) begin
              dq_o <= req_wdata_i; // data valid from setup until after the strobe
              dq_oe_o <= 1'b1;
              ext_q <= req_ext_i;
              // only extended writes stretch; normal ones use the plain strobe width
              if (req_ext_i) begin
                len_q <= (req_len_i < WC_CYC) ? WC_CYC : req_len_i;
              end else begin
                len_q <= WP_CYC;
              end
              state_q <= PSG_SETUP;
            end else begin
              oe_n_o <= 1'b0; // reads never wait on refresh
              state_q <= PSG_READ;
            end
          end
        end
        PSG_SETUP: begin
          we_n_o <= 1'b0;
          state_q <= PSG_STROBE;
        end
        PSG_STROBE: begin
          // guard wins over a long strobe: refresh starvation would corrupt the array
          if (stb_if.expired || sel_if.expired) begin
            we_n_o <= 1'b1;
            ce_n_o <= 1'b1; // address changes alone never free refresh
            trunc_o <= sel_if.expired && !stb_if.expired;
            state_q <= PSG_FINISH;
          end
        end
        PSG_READ: begin
          if (stb_if.expired) begin
            oe_n_o <= 1'b1;
            ce_n_o <= 1'b1;
            state_q <= PSG_FINISH;
          end
        end
        PSG_FINISH: begin
          dq_oe_o <= 1'b0; // hold data one cycle past the strobe
          done_o <= 1'b1;
          req_ready_o <= 1'b1; // standby cycle before any new access
          state_q <= PSG_IDLE;
        end
        default: begin
          state_q <= PSG_IDLE;
        end
      endcase
    end
  end

  // read data captured from the synchronised bus as output enable rises
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else if (state_q == PSG_READ && stb_if.expired) begin
      rdata_o <= dq_s2_q;
    end
  end

  // helper counters for the checks below
  logic [7:0] ce_low_cnt;
  logic [8:0] we_low_cnt;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || ce_n_o) begin
      ce_low_cnt <= 8'h00;
    end else if (ce_low_cnt != 8'hff) begin
      ce_low_cnt <= ce_low_cnt + 8'h01;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || we_n_o) begin
      we_low_cnt <= 9'h000;
    end else if (we_low_cnt != 9'h1ff) begin
      we_low_cnt <= we_low_cnt + 9'h001;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  sel_limit_a: assert property (!ce_n_o |-> ce_low_cnt < 8'd99)
    else $error("chip select held for 10 us or more");
  standby_gap_a: assert property ($rose(ce_n_o) |=> ce_n_o)
    else $error("chip select not held high between accesses");
  page_release_a: assert property (page_mode_i && $rose(we_n_o) |-> ce_n_o)
    else $error("chip select still low after a page mode write");
  // a reset inside an access also raises the strobes, so edges that follow a reset edge are skipped
  ext_strobe_a: assert property (!$past(srst_i) && $rose(we_n_o) && !trunc_o |-> we_low_cnt > {1'b0, len_q})
    else $error("write strobe shorter than requested width");
  data_window_a: assert property (!we_n_o |-> dq_oe_o && !ce_n_o && $past(dq_oe_o))
    else $error("data not driven around the write strobe");
  read_timing_a: assert property ($fell(oe_n_o) |-> (!oe_n_o && we_n_o && !dq_oe_o) [*4] ##1 oe_n_o)
    else $error("read pulse not of ordinary length");
  done_after_a: assert property (!$past(srst_i) && $rose(ce_n_o) |=> done_o && req_ready_o)
    else $error("completion not flagged after release");
  trunc_release_a: assert property (trunc_o |-> ce_n_o && we_n_o && ext_q)
    else $error("guard trip without releasing the ram");
  // the select guard must be counting, or just tripping, for as long as the strobe is low
  guard_armed_a: assert property (!we_n_o |-> sel_if.busy || sel_if.expired)
    else $error("write strobe low without a running select guard");
  // a read is always paced by the strobe timer, never left open-ended
  read_paced_a: assert property (state_q == PSG_READ |-> stb_if.busy || stb_if.expired)
    else $error("read pulse without a running pace timer");

  normal_write_c: cover property (accept && req_write_i && !req_ext_i ##[1:10] done_o);
  ext_write_c: cover property (accept && req_write_i && req_ext_i && req_len_i > 8'd4 ##[1:20] done_o);
  read_c: cover property (accept && !req_write_i ##[1:10] done_o);
  trunc_c: cover property (trunc_o);
endmodule // psg_write_guard

// *** test/psg_ram_model.sv ***
// behavioural pseudo-static ram on plain async pins, sixteen words deep
// assumes the host strobes change only after ref_clk_i rising edges
`timescale 1ns/1ns
module psg_ram_model (
  input wire logic ref_clk_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [21:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output int ce_low_o,
  output int we_low_o
);
  logic [15:0] mem [0:15];
  logic [15:0] last_q = 16'h0000;
  logic we_q = 1'b1;
  // refresh is internal and never seen at the pins
  // address changes are not used for refresh in either page mode
  always @(posedge ref_clk_i) begin
    ce_low_o <= ce_n_i ? 0 : ce_low_o + 1; // select time, judged by the bench
    we_q <= we_n_i;
    if (!we_n_i) we_low_o <= we_q ? 1 : we_low_o + 1; // strobe width of the last write
    if (!ce_n_i && !we_n_i) mem[addr_i[3:0]] <= dq_i; // data taken over the whole window
  end
  // reads never wait on refresh; a released bus shows the inverse, not the last word
  always_comb dq_o = (!ce_n_i && !oe_n_i && we_n_i) ? mem[addr_i[3:0]] : ~last_q;
  always @(posedge ref_clk_i) if (!oe_n_i) last_q <= dq_o;
endmodule // psg_ram_model

// *** test/psg_write_guard_bench.sv ***
// self-checking bench: write guard driving the behavioural ram model
// assumes design, package and model compiled before this file
`timescale 1ns/1ns
module psg_write_guard_bench;
  import psg_pkg::*;
  logic clk = 0, srst = 1, vld = 0, wr = 0, ext = 0, pm = 0, tr = 0;
  logic rdy, done, trunc, ce_n, we_n, oe_n, dq_oe;
  logic [21:0] addr = 22'h000000, a_o;
  logic [15:0] wdata = 16'h0000, rdata, dq_o, dq_i;
  psg_len_t len = 8'h00;
  int ce_low, we_low, ce_max = 0, cyc = 0, n_mismatch = 0, n_checks = 0;
  psg_write_guard dut (.ref_clk_i(clk), .srst_i(srst), .req_valid_i(vld), .req_write_i(wr),
    .req_ext_i(ext), .req_len_i(len), .req_addr_i(addr), .req_wdata_i(wdata), .page_mode_i(pm),
    .req_ready_o(rdy), .done_o(done), .trunc_o(trunc), .rdata_o(rdata), .ce_n_o(ce_n),
    .we_n_o(we_n), .oe_n_o(oe_n), .addr_o(a_o), .dq_o(dq_o), .dq_oe_o(dq_oe), .dq_i(dq_i));
  // undriven host bus shows the inverse, so a stale word cannot pass
  psg_ram_model ram (.ref_clk_i(clk), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(a_o),
    .dq_i(dq_oe ? dq_o : ~dq_o), .dq_o(dq_i), .ce_low_o(ce_low), .we_low_o(we_low));
  initial forever #50 clk = ~clk;
  // longest select run of the current access
  always @(posedge clk) #2 if (ce_low > ce_max) ce_max = ce_low;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask
  // every output at its idle value, as after any reset
  task chk_idle();
    chk(rdy, 1);
    chk(done, 0);
    chk(trunc, 0);
    chk(ce_n, 1);
    chk(we_n, 1);
    chk(oe_n, 1);
    chk(dq_oe, 0);
    chk(a_o, 22'h000000);
    chk(dq_o, 16'h0000);
    chk(rdata, 16'h0000);
  endtask
  // one access, then count cycles from the accept edge to done
  task go(input logic w, input logic e, input psg_len_t n, input logic [15:0] d);
    @(posedge clk);
    #1 vld = 1; wr = w; ext = e; len = n; wdata = d; ce_max = 0; tr = 0; cyc = 1;
    @(posedge clk);
    #1 vld = 0;
    while (done !== 1'b1 && cyc < 200) begin
      @(posedge clk);
      #1 cyc++;
      tr = tr | (trunc === 1'b1);
    end
  endtask
  task t_normal();
    pm = 0; addr = 22'h000003;
    go(1, 0, 8'h00, 16'h1234);
    chk(cyc, 5);
    chk(we_low, 2);
    chk(ce_n, 1);
    chk(tr, 0);
    chk(done, 1);
    chk(dq_o, 16'h1234);
    chk(dq_oe, 0);
    @(posedge clk);
    #1 chk(done, 0);
    go(0, 0, 8'h00, 16'h0000);
    chk(cyc, 6);
    chk(rdata, 16'h1234);
    chk(a_o, 22'h000003);
    chk(oe_n, 1);
    chk(rdy, 1);
    $display("normal write and read done");
  endtask
  task t_ext();
    addr = 22'h000005;
    go(1, 1, 8'h03, 16'hbeef);
    chk(we_low, 4);
    chk(cyc, 7);
    go(0, 0, 8'h00, 16'h0000);
    chk(rdata, 16'hbeef);
    // a length below the write cycle time is raised to it
    go(1, 1, 8'h00, 16'h1111);
    chk(we_low, 2);
    chk(cyc, 5);
    $display("extended write done");
  endtask
  task t_guard();
    pm = 1; addr = 22'h000009;
    go(1, 1, 8'hff, 16'h0f0f);
    chk(tr, 1);
    chk(ce_max < 100, 1);
    chk(cyc, 101);
    chk(ce_n, 1);
    go(0, 0, 8'h00, 16'h0000);
    chk(rdata, 16'h0f0f);
    $display("guarded write done");
  endtask
  // reset lands in the middle of a long write; the next access must still run normally
  task t_midreset();
    addr = 22'h00000c;
    @(posedge clk);
    #1 vld = 1; wr = 1; ext = 1; len = 8'hff; wdata = 16'h5a5a;
    @(posedge clk);
    #1 vld = 0;
    repeat (5) @(posedge clk);
    #1 chk(ce_n, 0);
    srst = 1;
    @(posedge clk);
    #1 srst = 0;
    chk_idle();
    go(1, 0, 8'h00, 16'h00a5);
    chk(cyc, 5);
    chk(ce_n, 1);
    $display("mid-run reset done");
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 srst = 0;
    chk_idle();
    $display("reset state done");
    t_normal();
    t_ext();
    t_guard();
    t_midreset();
    complete_run();
  end
  // about 160 cycles expected; cut off well after
  initial begin
    #300000;
    n_mismatch++;
    complete_run();
  end
endmodule // psg_write_guard_bench
